// ===== design/rar_pkg.sv
// Constants for the reset and access recovery block
package rar_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 4;
    // Coincident strobe low time for reset, ns
    localparam int unsigned STROBE_RESET_NS   = 150;
    localparam int unsigned STROBE_RESET_CYC  =
        (STROBE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Recovery in bus clock periods, tenths (3.5 and 3.0)
    localparam int unsigned RECOV_TENTHS      = 35;
    localparam int unsigned RECOV_ALIGN_TENTHS = 30;
    localparam int unsigned PCLK_PER_CYC      = 4;
    localparam int unsigned RECOV_CYC         =
        (RECOV_TENTHS * PCLK_PER_CYC + 9) / 10;
    localparam int unsigned RECOV_ALIGN_CYC   =
        (RECOV_ALIGN_TENTHS * PCLK_PER_CYC + 9) / 10;
    // Register addresses, reset command value and register reset values
    localparam logic [3:0] ADDR_PRIMARY_STATUS = 4'h0;
    localparam logic [3:0] ADDR_SPECIAL_STATUS = 4'h1;
    localparam logic [3:0] ADDR_VECTOR         = 4'h2;
    localparam logic [3:0] ADDR_RESET_CMD      = 4'h9;
    localparam logic [7:0] RESET_CMD_VALUE     = 8'hC0;
    localparam logic [7:0] PRIMARY_RESET_VAL   = 8'h44;
    localparam logic [7:0] SPECIAL_RESET_VAL   = 8'h06;
    localparam logic [7:0] VECTOR_RESET_VAL    = 8'h00;
endpackage

// ===== design/rar_strobe_timer.sv
// Coincident strobe detector with minimum-width counter
`timescale 1ns/1ns
module rar_strobe_timer #(
    parameter int unsigned WIDTH_CYC = rar_pkg::STROBE_RESET_CYC
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic rd_n_i,
    input  wire logic wr_n_i,
    output logic      reset_req_o
);
    logic [7:0] cnt_q;
    logic       fired_q;
    logic       both_low;

    assign both_low = !rd_n_i && !wr_n_i;

    // Short overlaps restart the count, so they never reach reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 8'h00;
        end else if (!both_low) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // One pulse per coincident period
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fired_q <= 1'b0;
        end else if (!both_low) begin
            fired_q <= 1'b0;
        end else if (reset_req_o) begin
            fired_q <= 1'b1;
        end
    end

    assign reset_req_o = both_low && !fired_q &&
        (cnt_q == 8'(WIDTH_CYC - 1));
endmodule

// ===== design/rar_core.sv
// Reset and host access recovery sequencer, top level
// How it works
// - Both strobes low together long enough forces a reset of both status registers; the vector register keeps its value.
// - Only accesses selecting this device start the recovery interval.
// - With clock-aligned strobes the recovery drops to three bus clocks.
// - Writing C0h to the reset command register resets both status registers like power-on.
// - Later resets need only the C0h write.
// - After reset the primary status register reads 44h.
// - After reset the special-condition status register reads 06h.
// - The vector written after reset reads back unchanged.
`timescale 1ns/1ns
module rar_core #(
    parameter int unsigned STROBE_CYC = rar_pkg::STROBE_RESET_CYC,
    parameter int unsigned RECOV_CYC  = rar_pkg::RECOV_CYC,
    parameter int unsigned ALIGN_CYC  = rar_pkg::RECOV_ALIGN_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       cs_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       aligned_i,
    input  wire logic       interrupt_acknowledge_in_i,
    input  wire logic       chain_enable_in_i,
    input  wire logic       irq_pending_i,
    output logic [7:0]      rdata_o,
    output logic            rdata_oe_o,
    output logic            chain_enable_out_o,
    output logic            chip_reset_o,
    output logic            recovery_busy_o,
    output logic            recovery_violation_o
);
    logic       strobe_reset;
    logic       rd_q;
    logic       wr_q;
    logic       access_end;
    logic       access_start;
    logic       cmd_reset;
    logic       reset_q;
    logic [7:0] primary_status_register_q;
    logic [7:0] special_condition_status_register_q;
    logic [7:0] vector_write_register_q;
    logic [7:0] rdata_q;
    logic [7:0] recov_cnt_q;
    logic       viol_q;
    logic [7:0] low_run_q;

    function automatic logic [7:0] read_mux(input logic [3:0] a,
                                            input logic [7:0] p,
                                            input logic [7:0] s,
                                            input logic [7:0] v);
        case (a)
            rar_pkg::ADDR_PRIMARY_STATUS: read_mux = p;
            rar_pkg::ADDR_SPECIAL_STATUS: read_mux = s;
            rar_pkg::ADDR_VECTOR:         read_mux = v;
            default:                      read_mux = 8'h00;
        endcase
    endfunction

    rar_strobe_timer #(
        .WIDTH_CYC (STROBE_CYC)
    ) u_timer (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .rd_n_i      (rd_n_i),
        .wr_n_i      (wr_n_i),
        .reset_req_o (strobe_reset)
    );

    // Access edges; a coincident reset strobe is not a normal access
    wire sel_rd = !cs_n_i && !rd_n_i && wr_n_i;
    wire sel_wr = !cs_n_i && !wr_n_i && rd_n_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= sel_rd;
            wr_q <= sel_wr;
        end
    end

    assign access_start = (sel_rd && !rd_q) || (sel_wr && !wr_q);
    assign access_end   = (rd_q && !sel_rd) || (wr_q && !sel_wr);
    assign cmd_reset    = sel_wr && !wr_q &&
        addr_i == rar_pkg::ADDR_RESET_CMD &&
        wdata_i == rar_pkg::RESET_CMD_VALUE;

    // Internal reset pulse, one cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reset_q <= 1'b1;
        end else begin
            reset_q <= strobe_reset || cmd_reset;
        end
    end

    // Status registers; serial logic would update the X bits
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            primary_status_register_q           <= rar_pkg::PRIMARY_RESET_VAL;
            special_condition_status_register_q <= rar_pkg::SPECIAL_RESET_VAL;
        end else if (reset_q) begin
            primary_status_register_q           <= rar_pkg::PRIMARY_RESET_VAL;
            special_condition_status_register_q <= rar_pkg::SPECIAL_RESET_VAL;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vector_write_register_q <= rar_pkg::VECTOR_RESET_VAL;
        end else if (sel_wr && !wr_q && addr_i == rar_pkg::ADDR_VECTOR) begin
            vector_write_register_q <= wdata_i;
        end
    end

    // Read data captured at the read start and held for the access
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else if (sel_rd && !rd_q) begin
            rdata_q <= read_mux(addr_i, primary_status_register_q,
                                special_condition_status_register_q,
                                vector_write_register_q);
        end
    end

    assign rdata_o    = rdata_q;
    assign rdata_oe_o = rd_q && sel_rd;

    // Recovery counter; the host owns spacing, we only flag breaches
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            recov_cnt_q <= 8'h00;
        end else if (access_end) begin
            recov_cnt_q <= aligned_i ? 8'(ALIGN_CYC) : 8'(RECOV_CYC);
        end else if (recov_cnt_q != 8'h00) begin
            recov_cnt_q <= recov_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            viol_q <= 1'b0;
        end else begin
            viol_q <= access_start && recov_cnt_q != 8'h00;
        end
    end

    assign recovery_busy_o      = recov_cnt_q != 8'h00;
    assign recovery_violation_o = viol_q;
    assign chip_reset_o         = reset_q;
    // Chain passes enable on when nothing is pending here; on host
    assign chain_enable_out_o = chain_enable_in_i && !irq_pending_i;

    // Own run of coincident lows, kept apart from the timer for the checks
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_run_q <= 8'h00;
        end else if (rd_n_i || wr_n_i) begin
            low_run_q <= 8'h00;
        end else if (low_run_q != 8'hFF) begin
            low_run_q <= low_run_q + 8'h01;
        end
    end

    chk_reset_from_cmd: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        cmd_reset |=> chip_reset_o)
        else $error("reset command did not reset");
    chk_reset_from_strb: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!rd_n_i && !wr_n_i && low_run_q == 8'(STROBE_CYC - 1))
        |=> chip_reset_o)
        else $error("coincident strobes did not reset");
    chk_no_short_reset: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rd_n_i || wr_n_i) && low_run_q != 8'h00 &&
        low_run_q < 8'(STROBE_CYC) && !cmd_reset |=> !chip_reset_o)
        else $error("brief overlap caused reset");
    chk_strobe_width: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        strobe_reset |-> low_run_q == 8'(STROBE_CYC - 1))
        else $error("strobe reset at wrong width");
    chk_primary_after: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        chip_reset_o |=> primary_status_register_q == 8'h44)
        else $error("primary status wrong after reset");
    chk_special_after: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        chip_reset_o |=> special_condition_status_register_q == 8'h06)
        else $error("special status wrong after reset");
    chk_vector_back: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (sel_wr && !wr_q && addr_i == rar_pkg::ADDR_VECTOR)
        |=> vector_write_register_q == $past(wdata_i))
        else $error("vector not stored");
    chk_recov_load: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        access_end |=> recov_cnt_q ==
            ($past(aligned_i) ? 8'(ALIGN_CYC) : 8'(RECOV_CYC)))
        else $error("recovery interval wrong");
    chk_recov_count: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        recovery_busy_o && !access_end
        |=> recov_cnt_q == $past(recov_cnt_q) - 8'h01)
        else $error("recovery count skipped");
    chk_recov_other: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (cs_n_i && recov_cnt_q == 8'h00 && !rd_q && !wr_q)
        |=> recov_cnt_q == 8'h00)
        else $error("foreign access counted");
    cov_cmd_reset: cover property (@(posedge clk_i) cmd_reset);
    cov_strobe_reset: cover property (@(posedge clk_i) strobe_reset);
    cov_violation: cover property (@(posedge clk_i) viol_q);
    cov_aligned: cover property (@(posedge clk_i) access_end && aligned_i);
endmodule

// ===== verif/rar_host.sv
// Host processor bus model facing the sequencer
`timescale 1ns/1ns
module rar_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic [3:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        cs_n_o  = 1'b1;
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        addr_o  = 4'hF;
        wdata_o = 8'h5A;
    end
    // Idle gap after each access is the host's recovery duty
    task automatic acc(input logic wr, input logic sel, input logic [3:0] a,
                       input logic [7:0] d, input int gap,
                       output logic [7:0] q);
        @(posedge clk_i);
        #1;
        cs_n_o  = ~sel;
        addr_o  = a;
        wdata_o = d;
        if (wr) begin
            wr_n_o = 1'b0;
        end else begin
            rd_n_o = 1'b0;
        end
        repeat (3) @(posedge clk_i);
        q = rdata_i;
        #1;
        cs_n_o  = 1'b1;
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        // Released lines flip so stale values never look valid
        addr_o  = ~a;
        wdata_o = ~d;
        repeat (gap) @(posedge clk_i);
    endtask
    task automatic both_low(input int n);
        @(posedge clk_i);
        #1;
        rd_n_o = 1'b0;
        wr_n_o = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        repeat (16) @(posedge clk_i);
    endtask
endmodule

// ===== verif/rar_core_tb.sv
// Self-checking bench for the reset and access recovery sequencer
`timescale 1ns/1ns
module rar_core_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i, cs_n, rd_n, wr_n, aligned, ack, cei, pend;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, q;
    logic oe, ceo, chip_reset_o, busy, recovery_violation_o;
    int fail_count = 0, cmp_count = 0, rst_cnt = 0, viol_cnt = 0, r0, v0;
    int oe_cnt = 0, o0;
    // Acknowledge read waits out the chain enable ripple
    localparam int ACK_WAIT = 2;
    always #2 clk_i = ~clk_i;
    rar_host u_host (.clk_i(clk_i), .rdata_i(rdata), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
    rar_core #(.STROBE_CYC(4)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
        .wdata_i(wdata), .aligned_i(aligned),
        .interrupt_acknowledge_in_i(ack), .chain_enable_in_i(cei),
        .irq_pending_i(pend), .rdata_o(rdata), .rdata_oe_o(oe),
        .chain_enable_out_o(ceo), .chip_reset_o(chip_reset_o),
        .recovery_busy_o(busy),
        .recovery_violation_o(recovery_violation_o));
    always @(posedge clk_i) begin
        if (!sys_rst_i && chip_reset_o === 1'b1) rst_cnt++;
        if (recovery_violation_o === 1'b1) viol_cnt++;
        if (oe === 1'b1) oe_cnt++;
    end
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic status_ok();
        o0 = oe_cnt;
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 16, q);
        chk("primary status", 8'h44, q & 8'hC7);
        u_host.acc(1'b0, 1'b1, 4'h1, 8'h00, 16, q);
        chk("special status", 8'h06, q & 8'hBF);
        // Two sampled edges of drive per three-edge read strobe
        chk("read enable", 8'(o0 + 4), 8'(oe_cnt));
    endtask
    task automatic t_cmd_reset();
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 16, q);
        u_host.acc(1'b0, 1'b1, 4'h1, 8'h00, 16, q);
        r0 = rst_cnt;
        u_host.acc(1'b1, 1'b1, 4'h9, 8'hC0, 16, q);
        chk("command reset", 8'(r0 + 1), 8'(rst_cnt));
        status_ok();
        u_host.acc(1'b1, 1'b1, 4'h2, 8'hA5, 16, q);
        u_host.acc(1'b0, 1'b1, 4'h2, 8'h00, 16, q);
        chk("vector readback", 8'hA5, q);
        r0 = rst_cnt;
        u_host.acc(1'b1, 1'b1, 4'h9, 8'hC0, 16, q);
        chk("later reset", 8'(r0 + 1), 8'(rst_cnt));
        status_ok();
        $display("command reset test done");
    endtask
    task automatic t_strobe_reset();
        r0 = rst_cnt;
        u_host.both_low(2);
        chk("brief overlap", 8'(r0), 8'(rst_cnt));
        u_host.both_low(4);
        chk("minimum overlap", 8'(r0 + 1), 8'(rst_cnt));
        u_host.both_low(12);
        chk("long overlap", 8'(r0 + 2), 8'(rst_cnt));
        status_ok();
        $display("strobe reset test done");
    endtask
    // Spacing pair: first access then gap, then a probe access
    task automatic pair(input logic al, input int gap, input int exp_v);
        aligned = al;
        v0 = viol_cnt;
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, gap, q);
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 16, q);
        chk("violations", 8'(v0 + exp_v), 8'(viol_cnt));
    endtask
    task automatic t_recovery();
        pair(1'b0, 16, 0);
        pair(1'b0, 10, 1);
        pair(1'b0, 12, 1);
        pair(1'b1, 12, 0);
        aligned = 1'b0;
        v0 = viol_cnt;
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 2, q);
        u_host.acc(1'b0, 1'b0, 4'h0, 8'h00, 10, q);
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 16, q);
        chk("other target", 8'(v0), 8'(viol_cnt));
        u_host.acc(1'b0, 1'b1, 4'h0, 8'h00, 2, q);
        #1;
        chk("busy start", 8'h01, {7'h00, busy});
        repeat (12) @(posedge clk_i);
        #1;
        chk("busy last", 8'h01, {7'h00, busy});
        @(posedge clk_i);
        #1;
        chk("busy end", 8'h00, {7'h00, busy});
        $display("recovery test done");
    endtask
    task automatic t_chain();
        @(posedge clk_i);
        #1;
        ack = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            #1;
            cei  = i[0];
            pend = i[1];
            repeat (ACK_WAIT) @(posedge clk_i);
            #1;
            chk("chain out", {7'h00, i[0] & ~i[1]}, {7'h00, ceo});
        end
        ack = 1'b0;
        $display("chain test done");
    endtask
    task automatic tally_and_finish();
        $display("Compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        {aligned, ack, pend, cei} = 4'h1;
        repeat (16) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        t_cmd_reset();
        t_strobe_reset();
        t_recovery();
        t_chain();
        tally_and_finish();
    end
    // Whole run is a few hundred cycles
    initial begin
        #60000;
        fail_count++;
        tally_and_finish();
    end
endmodule
